// [rtl/exec_pkg.sv]
// constants for the shift, subtract, test and stop execution block
package exec_pkg;
	localparam logic [7:0] OP_SET_CARRY = 8'h00DF;
	localparam logic [7:0] OP_ASR_R     = 8'h00D0;
	localparam logic [7:0] OP_ASR_IR    = 8'h00D1;
	localparam logic [7:0] OP_STOP      = 8'h007F;
	localparam logic [3:0] GRP_SUB      = 4'h2;
	localparam logic [3:0] GRP_TCM      = 4'h6;
	localparam logic [3:0] GRP_TM       = 4'h7;
	localparam logic [3:0] FORM_RR      = 4'h2;
	localparam logic [3:0] FORM_RIR     = 4'h3;
	localparam logic [3:0] FORM_GG      = 4'h4;
	localparam logic [3:0] FORM_GIR     = 4'h5;
	localparam logic [3:0] FORM_IM      = 4'h6;
	localparam logic [7:0] STOP_KEY     = 8'h00A5;
	localparam logic [15:0] RESET_VECTOR = 16'h0100;
	localparam logic [3:0] CYC_SHORT    = 4'h4;
	localparam logic [3:0] CYC_LONG     = 4'h6;
	localparam logic [1:0] LEN_ONE      = 2'h1;
	localparam logic [1:0] LEN_TWO      = 2'h2;
	localparam logic [1:0] LEN_THREE    = 2'h3;
	localparam logic [3:0] WREG_HI      = 4'h0;
	localparam int         FLAG_C       = 3;
	localparam int         FLAG_Z       = 2;
	localparam int         FLAG_S       = 1;
	localparam int         FLAG_V       = 0;
	localparam logic [3:0] FLAGS_RST    = 4'h0;
	localparam logic [7:0] STOPEN_RST   = 8'h0000;
	localparam logic [7:0] STOPEN_ADDR  = 8'h00D7;
	typedef enum logic [2:0] {ALU_NONE, ALU_SCF, ALU_ASR, ALU_SUB, ALU_TCM, ALU_TM} alu_op_t;
endpackage : exec_pkg

// [rtl/exec_alu_if.sv]
// operands and results between sequencer and alu
`timescale 1ns/1ps
`default_nettype none
interface exec_alu_if;
	import exec_pkg::*;
	alu_op_t    op;
	logic [7:0] dst;
	logic [7:0] src;
	logic [3:0] flags_in;
	logic [7:0] result;
	logic [3:0] flags_out;
	logic       write_dst;
	modport seq (output op, dst, src, flags_in, input result, flags_out, write_dst);
	modport alu (input op, dst, src, flags_in, output result, flags_out, write_dst);
endinterface : exec_alu_if
`default_nettype wire

// [rtl/exec_alu.sv]
// combinational alu for set carry, shift, subtract and mask tests
`timescale 1ns/1ps
`default_nettype none
module exec_alu
	import exec_pkg::*;
(
	exec_alu_if.alu a
);
	logic [8:0] diff;
	logic [7:0] r;
	always_comb
	begin
		diff        = {1'b0, a.dst} + {1'b0, ~a.src} + 9'h0001;
		r           = 8'h0000;
		a.flags_out = a.flags_in;
		a.write_dst = 1'b0;
		case (a.op)
			ALU_SCF:
			begin
				a.flags_out[FLAG_C] = 1'b1;
			end
			ALU_ASR:
			begin
				r = {a.dst[7], a.dst[7:1]};
				a.write_dst = 1'b1;
				a.flags_out = {a.dst[0], r == 8'h0000, r[7], 1'b0};
			end
			ALU_SUB:
			begin
				r = diff[7:0];
				a.write_dst = 1'b1;
				a.flags_out = {~diff[8], r == 8'h0000, r[7],
					(a.dst[7] != a.src[7]) && (r[7] == a.src[7])};
			end
			ALU_TCM:
			begin
				r = ~a.dst & a.src;
				a.flags_out = {a.flags_in[FLAG_C], r == 8'h0000, r[7], 1'b0};
			end
			ALU_TM:
			begin
				r = a.dst & a.src;
				a.flags_out = {a.flags_in[FLAG_C], r == 8'h0000, r[7], 1'b0};
			end
			default:
			begin
				r = 8'h0000;
			end
		endcase
		a.result = r;
	end
endmodule : exec_alu
`default_nettype wire

// [rtl/exec_core.sv]
// execution sequencer for set carry, shift, subtract, mask tests and stop
//
// Strobed register access and the register offsets were left to the implementer.
`timescale 1ns/1ps
`default_nettype none
module exec_core
	import exec_pkg::*;
(
	// clock and reset
	input  wire logic        clk_sys_in,
	input  wire logic        rst_in,
	// instruction fetch
	input  wire logic        start_in,
	input  wire logic [7:0]  opcode_in,
	input  wire logic [7:0]  byte1_in,
	input  wire logic [7:0]  byte2_in,
	// register file read and write
	output logic [7:0]       rf_addr_out,
	input  wire logic [7:0]  rf_rdata_in,
	output logic             rf_we_out,
	output logic [7:0]       rf_wdata_out,
	// stop enable register write port
	input  wire logic        stopen_we_in,
	input  wire logic [7:0]  stopen_wdata_in,
	// wake source
	input  wire logic        ext_int_in,
	// status
	output logic [3:0]       flags_out,
	output logic             busy_out,
	output logic             done_out,
	output logic [1:0]       length_out,
	output logic             clk_stop_out,
	output logic             pc_load_out,
	output logic [15:0]      pc_value_out,
	output logic             illegal_out
);
	typedef enum logic [2:0] {S_IDLE, S_PTR, S_SRC, S_DST, S_EXEC, S_WAIT, S_STOP} state_t;
	state_t      state_r;
	alu_op_t     op_r;
	logic [3:0]  form_r;
	logic [7:0]  dst_addr_r;
	logic [7:0]  src_addr_r;
	logic [7:0]  src_r;
	logic [7:0]  dst_r;
	logic [3:0]  flags_r;
	logic [7:0]  stopen_r;
	logic [3:0]  cyc_r;
	logic [3:0]  cyc_nxt;
	logic [3:0]  total_r;
	logic        is_stop_r;
	logic        done_r;
	logic        pc_load_r;
	logic        we_r;
	logic [7:0]  wdata_r;
	logic        illegal_r;
	logic [1:0]  len_r;
	logic [7:0]  rd_addr;
	alu_op_t     dec_op;
	logic        dec_ok;
	logic        dec_dual;
	logic [1:0]  dec_len;
	logic [3:0]  dec_cyc;
	logic        dec_stop;
	exec_alu_if  alu_bus();
	exec_alu u_alu (
		.a (alu_bus)
	);
	assign alu_bus.op       = op_r;
	assign alu_bus.dst      = dst_r;
	assign alu_bus.src      = src_r;
	assign alu_bus.flags_in = flags_r;
	// opcode decode by group and addressing form
	always_comb
	begin
		dec_op   = ALU_NONE;
		dec_ok   = 1'b1;
		dec_dual = 1'b0;
		dec_len  = LEN_ONE;
		dec_cyc  = CYC_SHORT;
		dec_stop = 1'b0;
		if (opcode_in == OP_SET_CARRY)
		begin
			dec_op = ALU_SCF;
		end
		else if (opcode_in == OP_STOP)
		begin
			dec_stop = 1'b1;
		end
		else if (opcode_in == OP_ASR_R || opcode_in == OP_ASR_IR)
		begin
			dec_op  = ALU_ASR;
			dec_len = LEN_TWO;
		end
		else if ((opcode_in[7:4] == GRP_SUB || opcode_in[7:4] == GRP_TCM
			|| opcode_in[7:4] == GRP_TM) && opcode_in[3:0] >= FORM_RR
			&& opcode_in[3:0] <= FORM_IM)
		begin
			dec_dual = 1'b1;
			dec_op   = (opcode_in[7:4] == GRP_SUB) ? ALU_SUB :
				(opcode_in[7:4] == GRP_TCM) ? ALU_TCM : ALU_TM;
			dec_len  = (opcode_in[3:0] >= FORM_GG) ? LEN_THREE : LEN_TWO;
			dec_cyc  = (opcode_in[3:0] == FORM_RR) ? CYC_SHORT : CYC_LONG;
		end
		else
		begin
			dec_ok = 1'b0;
		end
	end
	always_comb
	begin
		case (state_r)
			S_PTR:   rd_addr = src_addr_r;
			S_SRC:   rd_addr = (form_r == FORM_RIR || form_r == FORM_GIR
				|| form_r == OP_ASR_IR[3:0]) ? src_r : src_addr_r;
			S_DST:   rd_addr = dst_addr_r;
			default: rd_addr = dst_addr_r;
		endcase
	end
	assign rf_addr_out = rd_addr;
	assign cyc_nxt     = cyc_r + 4'h1;
	// sequencer
	always_ff @(posedge clk_sys_in or posedge rst_in)
	begin
		if (rst_in)
		begin
			state_r    <= S_IDLE;
			op_r       <= ALU_NONE;
			form_r     <= 4'h0;
			dst_addr_r <= 8'h0000;
			src_addr_r <= 8'h0000;
			src_r      <= 8'h0000;
			dst_r      <= 8'h0000;
			cyc_r      <= 4'h0;
			total_r    <= CYC_SHORT;
			is_stop_r  <= 1'b0;
			illegal_r  <= 1'b0;
			len_r      <= LEN_ONE;
		end
		else
		begin
			illegal_r <= 1'b0;
			case (state_r)
				S_IDLE:
				begin
					cyc_r <= 4'h1;
					if (start_in && !dec_ok)
					begin
						illegal_r <= 1'b1;
					end
					else if (start_in)
					begin
						op_r      <= dec_op;
						form_r    <= opcode_in[3:0];
						total_r   <= dec_cyc;
						is_stop_r <= dec_stop;
						len_r     <= dec_len;
						if (dec_dual && opcode_in[3:0] <= FORM_RIR)
						begin
							dst_addr_r <= {WREG_HI, byte1_in[7:4]};
							src_addr_r <= {WREG_HI, byte1_in[3:0]};
						end
						else if (opcode_in[3:0] == FORM_IM)
						begin
							dst_addr_r <= byte1_in;
							src_r      <= byte2_in;
						end
						else if (dec_dual)
						begin
							src_addr_r <= byte1_in;
							dst_addr_r <= byte2_in;
						end
						else
						begin
							src_addr_r <= byte1_in;
						end
						if (dec_op == ALU_ASR && opcode_in == OP_ASR_IR)
						begin
							state_r <= S_PTR;
						end
						else if (dec_op == ALU_ASR)
						begin
							state_r <= S_DST;
							dst_addr_r <= byte1_in;
						end
						else if (dec_dual && opcode_in[3:0] == FORM_IM)
						begin
							state_r <= S_DST;
						end
						else if (dec_dual && (opcode_in[3:0] == FORM_RIR
							|| opcode_in[3:0] == FORM_GIR))
						begin
							state_r <= S_PTR;
						end
						else if (dec_dual)
						begin
							state_r <= S_SRC;
						end
						else
						begin
							state_r <= S_WAIT;
						end
					end
				end
				S_PTR:
				begin
					cyc_r <= cyc_nxt;
					src_r <= rf_rdata_in;
					if (op_r == ALU_ASR)
					begin
						dst_addr_r <= rf_rdata_in;
						state_r    <= S_DST;
					end
					else
					begin
						state_r <= S_SRC;
					end
				end
				S_SRC:
				begin
					cyc_r   <= cyc_nxt;
					src_r   <= rf_rdata_in;
					state_r <= S_DST;
				end
				S_DST:
				begin
					cyc_r   <= cyc_nxt;
					dst_r   <= rf_rdata_in;
					state_r <= S_EXEC;
				end
				S_EXEC:
				begin
					cyc_r   <= cyc_nxt;
					state_r <= S_WAIT;
				end
				S_WAIT:
				begin
					if (cyc_r >= total_r)
					begin
						state_r <= (is_stop_r && stopen_r == STOP_KEY) ? S_STOP : S_IDLE;
						op_r    <= ALU_NONE;
					end
					else
					begin
						cyc_r <= cyc_nxt;
					end
				end
				S_STOP:
				begin
					if (ext_int_in)
					begin
						state_r <= S_IDLE;
					end
				end
				default:
				begin
					state_r <= S_IDLE;
				end
			endcase
		end
	end
	// flag register, written at execute, or in the last wait cycle for set carry; stop leaves it alone
	always_ff @(posedge clk_sys_in or posedge rst_in)
	begin
		if (rst_in)
		begin
			flags_r <= FLAGS_RST;
		end
		else if ((state_r == S_EXEC) || (state_r == S_WAIT && op_r == ALU_SCF
			&& cyc_r >= total_r))
		begin
			flags_r <= alu_bus.flags_out;
		end
	end
	// destination write-back; tests leave both operands alone
	always_ff @(posedge clk_sys_in or posedge rst_in)
	begin
		if (rst_in)
		begin
			we_r    <= 1'b0;
			wdata_r <= 8'h0000;
		end
		else
		begin
			we_r    <= (state_r == S_EXEC) && alu_bus.write_dst;
			wdata_r <= alu_bus.result;
		end
	end
	// stop key register; frozen while stopped
	always_ff @(posedge clk_sys_in or posedge rst_in)
	begin
		if (rst_in)
		begin
			stopen_r <= STOPEN_RST;
		end
		else if (stopen_we_in && state_r != S_STOP)
		begin
			stopen_r <= stopen_wdata_in;
		end
	end
	// completion and reset-vector load
	always_ff @(posedge clk_sys_in or posedge rst_in)
	begin
		if (rst_in)
		begin
			done_r    <= 1'b0;
			pc_load_r <= 1'b0;
		end
		else
		begin
			done_r    <= (state_r == S_WAIT) && (cyc_r >= total_r);
			pc_load_r <= (state_r == S_WAIT) && (cyc_r >= total_r)
				&& is_stop_r && (stopen_r != STOP_KEY);
		end
	end
	assign rf_we_out    = we_r;
	assign rf_wdata_out = wdata_r;
	assign flags_out    = flags_r;
	assign busy_out     = (state_r != S_IDLE);
	assign done_out     = done_r;
	assign length_out   = len_r;
	assign clk_stop_out = (state_r == S_STOP);
	assign pc_load_out  = pc_load_r;
	assign pc_value_out = RESET_VECTOR;
	assign illegal_out  = illegal_r;
	stop_flags_a: assert property (@(posedge clk_sys_in) disable iff (rst_in)
		(state_r == S_STOP) |=> $stable(flags_r))
		else $error("flags changed while stopped");
	stop_key_a: assert property (@(posedge clk_sys_in) disable iff (rst_in)
		(clk_stop_out && !$past(clk_stop_out)) |-> $past(stopen_r) == STOP_KEY)
		else $error("stop entered without key");
	stop_wake_a: assert property (@(posedge clk_sys_in) disable iff (rst_in)
		(clk_stop_out && !ext_int_in) |=> clk_stop_out)
		else $error("stop left without wake");
	scf_carry_a: assert property (@(posedge clk_sys_in) disable iff (rst_in)
		(start_in && !busy_out && opcode_in == OP_SET_CARRY) |-> ##5 done_out ##0
		flags_r[FLAG_C] && flags_r[2:0] == $past(flags_r[2:0], 5))
		else $error("set carry wrong");
	test_nowrite_a: assert property (@(posedge clk_sys_in) disable iff (rst_in)
		(state_r == S_EXEC && (op_r == ALU_TM || op_r == ALU_TCM)) |=> !rf_we_out)
		else $error("test wrote operand");
	test_carry_a: assert property (@(posedge clk_sys_in) disable iff (rst_in)
		(state_r == S_EXEC && op_r != ALU_SUB && op_r != ALU_ASR) |=>
		flags_r[FLAG_C] == $past(flags_r[FLAG_C]) && !flags_r[FLAG_V])
		else $error("test flags wrong");
	asr_result_a: assert property (@(posedge clk_sys_in) disable iff (rst_in)
		(state_r == S_EXEC && op_r == ALU_ASR) |=> rf_we_out
		&& rf_wdata_out == {$past(dst_r[7]), $past(dst_r[7:1])}
		&& flags_r[FLAG_C] == $past(dst_r[0]) && !flags_r[FLAG_V])
		else $error("shift wrong");
	sub_result_a: assert property (@(posedge clk_sys_in) disable iff (rst_in)
		(state_r == S_EXEC && op_r == ALU_SUB) |=>
		rf_wdata_out == 8'($past(dst_r) - $past(src_r))
		&& flags_r[FLAG_C] == ($past(src_r) > $past(dst_r)))
		else $error("subtract wrong");
endmodule : exec_core
`default_nettype wire

// [verification/tb.sv]
// self-checking bench for the execution sequencer
`timescale 1ns/1ps
`default_nettype none
module tb;
	import exec_pkg::*;
	logic        clk_sys_in = 1'b0;
	logic        rst_in = 1'b1;
	logic        start_in = 1'b0;
	logic [7:0]  opcode_in = '0;
	logic [7:0]  byte1_in = '0;
	logic [7:0]  byte2_in = '0;
	logic [7:0]  stopen_wdata_in = '0;
	logic        stopen_we_in = 1'b0;
	logic        ext_int_in = 1'b0;
	logic [7:0]  rf_addr_out, rf_rdata_in, rf_wdata_out, wr_d, wr_a, b1, b2, r;
	logic [3:0]  flags_out, fl;
	logic        rf_we_out, busy_out, done_out, clk_stop_out, pc_load_out, illegal_out;
	logic [1:0]  length_out;
	logic [15:0] pc_value_out;
	logic [7:0]  mem [256];
	logic [7:0]  dv [4] = '{8'h0083, 8'h0080, 8'h0055, 8'h007F};
	logic [7:0]  sv [4] = '{8'h0092, 8'h0001, 8'h0055, 8'h0080};
	logic [3:0]  grp;
	int          failures = 0;
	int          compares = 0;
	int          cyc = 0;
	int          n, wr_n, pcl_n, ill_n;

	always #2.5 clk_sys_in = ~clk_sys_in;
	// register file answers in the same cycle
	assign rf_rdata_in = mem[rf_addr_out];

	exec_core dut (.clk_sys_in, .rst_in, .start_in, .opcode_in, .byte1_in, .byte2_in,
		.rf_addr_out, .rf_rdata_in, .rf_we_out, .rf_wdata_out, .stopen_we_in,
		.stopen_wdata_in, .ext_int_in, .flags_out, .busy_out, .done_out, .length_out,
		.clk_stop_out, .pc_load_out, .pc_value_out, .illegal_out);

	task automatic wrap_up();
		$display("compares %0d failures %0d", compares, failures);
		if (failures == 0 && compares > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask : wrap_up

	always @(posedge clk_sys_in)
	begin
		cyc++;
		if (cyc == 20000)
		begin
			failures++;
			wrap_up();
		end
	end

	task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
		compares++;
		if (got !== exp)
		begin
			failures++;
			$display("unexpected %s expected %h seen %h", what, exp, got);
		end
	endtask : chk

	// one instruction; counts cycles to done and the side pulses
	task automatic exec(input logic [7:0] op, input logic [7:0] x1, input logic [7:0] x2);
		@(posedge clk_sys_in);
		start_in <= 1'b1;
		opcode_in <= op;
		byte1_in <= x1;
		byte2_in <= x2;
		@(posedge clk_sys_in);
		start_in <= 1'b0;
		n = 0;
		wr_n = 0;
		pcl_n = 0;
		// illegal pulse stands only in the cycle right after the take
		#1;
		ill_n = (illegal_out === 1'b1);
		while (done_out !== 1'b1 && n < 12)
		begin
			@(posedge clk_sys_in);
			#1;
			n++;
			wr_n += (rf_we_out === 1'b1);
			pcl_n += (pc_load_out === 1'b1);
			ill_n += (illegal_out === 1'b1);
			if (rf_we_out === 1'b1)
			begin
				wr_d = rf_wdata_out;
				wr_a = rf_addr_out;
			end
		end
	endtask : exec

	// operands placed for every addressing form
	task automatic setup(input logic [3:0] f, input logic [7:0] d, input logic [7:0] s);
		mem[8'h03] = d;
		mem[8'h21] = d;
		mem[8'h05] = s;
		mem[8'h22] = s;
		mem[8'h40] = s;
		mem[8'h50] = s;
		mem[8'h04] = 8'h0040;
		mem[8'h23] = 8'h0050;
		b1 = f == FORM_RR ? 8'h0035 : f == FORM_RIR ? 8'h0034 : f == FORM_GG ? 8'h0022 :
			f == FORM_GIR ? 8'h0023 : 8'h0021;
		b2 = f == FORM_IM ? s : 8'h0021;
	endtask : setup

	task automatic set_carry_op();
		fl[FLAG_C] = 1'b1;
		exec(OP_SET_CARRY, 8'h0000, 8'h0000);
		chk("scf flags", fl, flags_out);
		chk("scf cycles", 4, n);
		chk("scf length", LEN_ONE, length_out);
	endtask : set_carry_op

	task automatic key(input logic [7:0] v);
		@(posedge clk_sys_in);
		stopen_we_in <= 1'b1;
		stopen_wdata_in <= v;
		@(posedge clk_sys_in);
		stopen_we_in <= 1'b0;
	endtask : key

	initial
	begin
		for (int i = 0; i < 256; i++)
			mem[i] = 8'(i);
		fl = FLAGS_RST;
		repeat (3) @(posedge clk_sys_in);
		rst_in <= 1'b0;
		@(posedge clk_sys_in);
		#1;
		chk("reset flags", fl, flags_out);
		chk("reset stop", 0, clk_stop_out);
		$display("test reset done");
		for (int g = 0; g < 3; g++)
			for (int f = 2; f < 7; f++)
				for (int p = 0; p < 4; p++)
				begin
					if (p == 2)
						set_carry_op();
					grp = g == 0 ? GRP_SUB : g == 1 ? GRP_TCM : GRP_TM;
					setup(4'(f), dv[p], sv[p]);
					r = grp == GRP_SUB ? dv[p] - sv[p] : grp == GRP_TCM ? ~dv[p] & sv[p] : dv[p] & sv[p];
					fl[FLAG_C] = grp == GRP_SUB ? sv[p] > dv[p] : fl[FLAG_C];
					fl[FLAG_V] = grp == GRP_SUB && dv[p][7] != sv[p][7] && r[7] == sv[p][7];
					fl[FLAG_Z] = r == 8'h0000;
					fl[FLAG_S] = r[7];
					exec({grp, 4'(f)}, b1, b2);
					chk("op flags", fl, flags_out);
					chk("op cycles", f == 2 ? 4 : 6, n);
					chk("op length", f < 4 ? 2 : 3, length_out);
					chk("op writes", grp == GRP_SUB, wr_n);
					if (grp == GRP_SUB)
					begin
						chk("sub result", r, wr_d);
						chk("sub address", f < 4 ? 8'h0003 : 8'h0021, wr_a);
					end
				end
		$display("test subtract and mask done");
		for (int p = 0; p < 6; p++)
		begin
			setup(p < 3 ? FORM_GG : FORM_GIR, 8'h0000, dv[p % 3] ^ 8'h001A);
			r = dv[p % 3] ^ 8'h001A;
			fl = {r[0], r[7:1] == 7'h00 && r[7] == 1'b0, r[7], 1'b0};
			r = {r[7], r[7:1]};
			exec(p < 3 ? OP_ASR_R : OP_ASR_IR, b1, b2);
			chk("asr result", r, wr_d);
			chk("asr address", p < 3 ? 8'h0022 : 8'h0050, wr_a);
			chk("asr flags", fl, flags_out);
			chk("asr cycles", 4, n);
			chk("asr length", LEN_TWO, length_out);
		end
		$display("test shift done");
		key(STOP_KEY ^ 8'h0001);
		exec(OP_STOP, 8'h0000, 8'h0000);
		chk("stop reload", 1, pcl_n);
		chk("stop vector", RESET_VECTOR, pc_value_out);
		chk("stop halted", 0, clk_stop_out);
		chk("stop cycles", 4, n);
		chk("stop flags", fl, flags_out);
		key(STOP_KEY);
		exec(OP_STOP, 8'h0000, 8'h0000);
		chk("stop entered", 1, clk_stop_out);
		repeat (20) @(posedge clk_sys_in);
		#1;
		chk("stop held", 1, clk_stop_out);
		chk("stop flags kept", fl, flags_out);
		chk("stop busy", 1, busy_out);
		@(posedge clk_sys_in);
		ext_int_in <= 1'b1;
		@(posedge clk_sys_in);
		ext_int_in <= 1'b0;
		repeat (3) @(posedge clk_sys_in);
		#1;
		chk("wake by interrupt", 0, clk_stop_out);
		chk("awake idle", 0, busy_out);
		key(STOP_KEY);
		exec(OP_STOP, 8'h0000, 8'h0000);
		chk("stop again", 1, clk_stop_out);
		@(posedge clk_sys_in);
		rst_in <= 1'b1;
		repeat (3) @(posedge clk_sys_in);
		rst_in <= 1'b0;
		@(posedge clk_sys_in);
		#1;
		chk("wake by reset", 0, clk_stop_out);
		$display("test stop done");
		exec(8'h0000, 8'h0000, 8'h0000);
		chk("unknown opcode", 1, ill_n);
		$display("test unknown opcode done");
		wrap_up();
	end
endmodule : tb
`default_nettype wire
